/* File: hdl/visc_core.sv */
// Source-control front end of the vectored interrupt controller
`timescale 1ns/10ps

// Operation
// (RL1) Thirty-two maskable sources resolved by eight priority levels into vectors.
// (RL2) Drive active-low fast and normal request lines from internal and external sources.
// (RL3) Internal sources select level or edge; polarity handled inside.
// (RL4) External sources select high, low, rising or falling condition.
// (RL5) Fast redirect routes any source to the fast request line.
// (RL6) Runs on the continuous system clock; no gating dependency.
// (RL7) Either request asserted produces the processor wake-up output.
// (RL8) Wake-only mask wakes processor without asserting request lines.
// (RL9) Source 0 is the fast source pin.
// (RL10) Source 1 is the OR of all system peripheral lines.
// (RL11) Sources 2 to 31 come from peripherals or external lines.
// (RL12) Each source has its own mode register with a type field.
// (RL13) Enable and disable commands write ones; mask readable.
// (RL14) Disabled sources never affect prioritisation of enabled ones.
// (RL15) Set and clear commands act on edge latches of edge sources.
// (RL16) Set and clear commands do nothing on level sources.
// (RL17) Vector read clears the edge latch of the chosen current source only.
// (RL18) Vector read auto clear skips sources with fast redirect.
// (RL19) Fast vector read clears the edge latch of source 0.
// (RL20) Pending shows activity regardless of mask; mask shown separately.
// (RL21) Current source register returns the serviced source number.
// (RL22) Core status returns present fast and normal line state.
// (RL23) Each source has a priority 7 highest down to 0 lowest.
// (RL24) Equal priorities at vector read pick the lowest source number.
// (RL25) Vector read deasserts the normal request line.
// (RL26) External inputs synchronised; detected edges stay latched until cleared.
// (RL27) Reset disables all sources, clears latches, requests high.
module visc_core #(
  parameter int NUM_SRC = 32,
  parameter logic [31:0] EXT_MASK = 32'h0000_0001 // Sources fed from pins, bit 0 always
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Source inputs
  input  wire logic        fast_source_pin_i,
  input  wire logic [7:0]  system_lines_i,
  input  wire logic [29:0] peripheral_sources_i,
  // Register port
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Processor side
  output logic             fast_request_n_o,
  output logic             normal_request_n_o,
  output logic             wake_o
);
  // Elaboration checks: the source map is fixed and source 0 is always a pin
  if (NUM_SRC != 32) begin : g_num_src_check // RL1
    $error("visc_core serves exactly 32 sources");
  end
  if (EXT_MASK[0] != 1'b1) begin : g_ext_mask_check
    $error("visc_core needs source 0 marked as a pin source");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]            in_s1;
    logic [31:0]            in_s2;
    logic [31:0]            in_prev;
    logic [31:0]            edge_lat;
    logic [31:0]            mask;
    logic [31:0]            fast_redir;
    logic [31:0][6:0]       mode;
    logic                   wake_only;
    logic [4:0]             current;
    logic [2:0]             cur_prio;
    visc_pkg::visc_state_type st;
    logic                   normal_request_n;
    logic                   fast_request_n;
    logic [31:0]            rdata;
  } visc_regs_type;

  visc_regs_type q, d;
  logic rst_n;
  logic [1:0] rsync_q;

  // Reset release through two flops; only the second is used
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // Is the source in an edge mode
  function automatic logic is_edge(input logic [6:0] m);
    return m[visc_pkg::TYPE_LSB];
  endfunction

  // ----------------------------------------------------------------
  // Combinational
  // ----------------------------------------------------------------
  logic [31:0] raw;
  logic [31:0] active;
  logic [31:0] pending;
  logic [31:0] enabled_pend;
  logic [4:0]  best_src;
  logic [2:0]  best_prio;
  logic        best_found;
  logic        fast_req;
  logic        norm_req;

  // Source map: 0 pin, 1 OR of system lines, rest peripherals
  assign raw = {peripheral_sources_i, |system_lines_i, fast_source_pin_i}; // RL9 RL10 RL11

  // Per-source condition; edges latched, levels direct
  always_comb begin
    active = '0;
    for (int i = 0; i < 32; i++) begin
      logic [1:0] t;
      logic ext;
      t = q.mode[i][visc_pkg::TYPE_MSB:visc_pkg::TYPE_LSB];
      ext = EXT_MASK[i];
      if (!is_edge(q.mode[i])) begin
        // Internal lines are active high whatever the code
        if (ext && t == visc_pkg::TYPE_LOW_LEVEL) active[i] = !q.in_s2[i]; // RL4
        else active[i] = q.in_s2[i]; // RL3
      end
    end
  end
  assign pending = active | q.edge_lat; // RL20
  assign enabled_pend = pending & q.mask; // RL14

  // Highest priority, lowest number wins; redirected sources excluded
  always_comb begin
    best_src = 5'h00;
    best_prio = 3'h0;
    best_found = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (enabled_pend[i] && !q.fast_redir[i]) begin
        if (!best_found || q.mode[i][visc_pkg::PRIO_MSB:visc_pkg::PRIO_LSB] > best_prio) begin // RL23 RL24
          best_found = 1'b1;
          best_src = 5'(i);
          best_prio = q.mode[i][visc_pkg::PRIO_MSB:visc_pkg::PRIO_LSB];
        end
      end
    end
  end

  // Fast line: source 0 plus redirected sources
  assign fast_req = enabled_pend[0] | |(enabled_pend & q.fast_redir); // RL5
  // Normal line only above the level in service
  assign norm_req = best_found && (q.st == visc_pkg::VISC_IDLE || best_prio > q.cur_prio);

  // Next-state logic
  always_comb begin
    logic [31:0] set_m;
    logic [31:0] clr_m;
    logic [31:0] edges;
    d = q;
    set_m = '0;
    clr_m = '0;
    edges = '0;
    d.in_s1 = raw; // RL26
    d.in_s2 = q.in_s1;
    d.in_prev = q.in_s2;
    d.rdata = 32'h0000_0000;
    // Edge detection on synchronised inputs
    for (int i = 0; i < 32; i++) begin
      logic [1:0] t;
      t = q.mode[i][visc_pkg::TYPE_MSB:visc_pkg::TYPE_LSB];
      edges[i] = (EXT_MASK[i] && t == visc_pkg::TYPE_FALL_EDGE) ? (q.in_prev[i] && !q.in_s2[i])
                                                             : (!q.in_prev[i] && q.in_s2[i]);
    end
    // Register writes
    if (wr_i) begin
      if (addr_i < visc_pkg::VECTOR_OFS) d.mode[addr_i[6:2]] = wdata_i[6:0]; // RL12
      case (addr_i)
        visc_pkg::ENABLE_CMD_OFS:    d.mask = q.mask | wdata_i; // RL13
        visc_pkg::DISABLE_CMD_OFS:   d.mask = q.mask & ~wdata_i; // RL13
        visc_pkg::SET_CMD_OFS:       set_m = wdata_i; // RL15
        visc_pkg::CLEAR_CMD_OFS:     clr_m = wdata_i; // RL15
        visc_pkg::FAST_REDIRECT_OFS: d.fast_redir = wdata_i & ~32'h0000_0001;
        visc_pkg::CONTROL_OFS:       d.wake_only = wdata_i[visc_pkg::CTRL_WAKE_ONLY_BIT];
        visc_pkg::END_SERVICE_OFS: begin
          d.st = visc_pkg::VISC_IDLE;
          d.current = visc_pkg::NO_SOURCE;
        end
        default: ;
      endcase
    end
    // Register reads, data one cycle later
    if (rd_i) begin
      if (addr_i < visc_pkg::VECTOR_OFS) d.rdata = {25'h0, q.mode[addr_i[6:2]]};
      case (addr_i)
        visc_pkg::VECTOR_OFS: begin
          d.rdata = {27'h0, best_src};
          if (best_found) begin
            d.current = best_src; // RL21
            d.cur_prio = best_prio;
            d.st = visc_pkg::VISC_BUSY;
            if (is_edge(q.mode[best_src])) clr_m[best_src] = 1'b1; // RL17 RL18
          end
        end
        visc_pkg::FAST_VECTOR_OFS: begin
          d.rdata = 32'h0000_0000;
          if (is_edge(q.mode[0])) clr_m[0] = 1'b1; // RL19
        end
        visc_pkg::CURRENT_SOURCE_OFS: d.rdata = {27'h0, q.current}; // RL21
        visc_pkg::PENDING_OFS:        d.rdata = pending; // RL20
        visc_pkg::MASK_OFS:           d.rdata = q.mask; // RL13
        visc_pkg::CORE_STATUS_OFS: begin
          d.rdata[visc_pkg::CORE_FAST_BIT] = !q.fast_request_n; // RL22
          d.rdata[visc_pkg::CORE_NORMAL_BIT] = !q.normal_request_n; // RL22
        end
        visc_pkg::FAST_REDIRECT_OFS:  d.rdata = q.fast_redir;
        visc_pkg::CONTROL_OFS:        d.rdata = {31'h0, q.wake_only};
        default: ;
      endcase
    end
    // Latches: hardware edge wins over a clear; level sources ignore commands
    for (int i = 0; i < 32; i++) begin
      if (is_edge(q.mode[i])) begin
        if (edges[i] || set_m[i]) d.edge_lat[i] = 1'b1; // RL15 RL26
        else if (clr_m[i]) d.edge_lat[i] = 1'b0;
      end else begin
        d.edge_lat[i] = 1'b0; // RL16
      end
    end
    // Lines: normal drops in the cycle after a vector read
    d.fast_request_n = !(fast_req && !q.wake_only); // RL5 RL8
    d.normal_request_n = !(norm_req && !q.wake_only && !(rd_i && addr_i == visc_pkg::VECTOR_OFS)); // RL25 RL8
  end

  // Single register bank on the continuous clock
  always_ff @(posedge clk_i or negedge rst_n) begin // RL6
    if (!rst_n) begin
      q <= '0; // RL27
      q.st <= visc_pkg::VISC_IDLE;
      q.normal_request_n <= 1'b1; // RL27
      q.fast_request_n <= 1'b1; // RL27
      q.mask <= visc_pkg::MASK_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign rdata_o = q.rdata;
  assign fast_request_n_o = q.fast_request_n; // RL2
  assign normal_request_n_o = q.normal_request_n; // RL2
  assign wake_o = fast_req | norm_req; // RL7 RL8

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_lines;
    @(posedge clk_i) $rose(rst_n) |-> fast_request_n_o && normal_request_n_o && q.mask == 32'h0;
  endproperty
  a_reset_lines: assert property (p_reset_lines) else $error("lines not high after reset"); // RL27

  property p_enable;
    @(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == visc_pkg::ENABLE_CMD_OFS |=> (q.mask & $past(wdata_i)) == $past(wdata_i);
  endproperty
  a_enable: assert property (p_enable) else $error("enable command lost"); // RL13

  property p_disable;
    @(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == visc_pkg::DISABLE_CMD_OFS |=> (q.mask & $past(wdata_i)) == 32'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("disable command lost"); // RL13

  property p_level_no_latch;
    @(posedge clk_i) disable iff (!rst_n) !is_edge(q.mode[2]) |=> !q.edge_lat[2];
  endproperty
  a_level_no_latch: assert property (p_level_no_latch) else $error("level source latched"); // RL16

  property p_set_cmd;
    @(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == visc_pkg::SET_CMD_OFS && wdata_i[2] && is_edge(q.mode[2])
      |=> q.edge_lat[2];
  endproperty
  a_set_cmd: assert property (p_set_cmd) else $error("set command ignored"); // RL15

  property p_vector_deasserts;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == visc_pkg::VECTOR_OFS |=> normal_request_n_o;
  endproperty
  a_vector_deasserts: assert property (p_vector_deasserts) else $error("normal line held after vector"); // RL25

  property p_core_status;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == visc_pkg::CORE_STATUS_OFS |=> rdata_o[1:0] == ~{$past(q.normal_request_n), $past(q.fast_request_n)};
  endproperty
  a_core_status: assert property (p_core_status) else $error("core status mismatch"); // RL22

  property p_pending_read;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == visc_pkg::PENDING_OFS |=> rdata_o == $past(pending);
  endproperty
  a_pending_read: assert property (p_pending_read) else $error("pending read mismatch"); // RL20

  property p_fast_line;
    @(posedge clk_i) disable iff (!rst_n) fast_req && !q.wake_only |=> !fast_request_n_o;
  endproperty
  a_fast_line: assert property (p_fast_line) else $error("fast line not asserted"); // RL5

  property p_wake_only;
    @(posedge clk_i) disable iff (!rst_n) $past(q.wake_only) |-> fast_request_n_o && normal_request_n_o;
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("line asserted in wake-only mode"); // RL8

  // Vector read records the winner as current and hands back its number
  property p_vector_current;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == visc_pkg::VECTOR_OFS && best_found
      |=> q.current == $past(best_src) && rdata_o == {27'h0, $past(best_src)};
  endproperty
  a_vector_current: assert property (p_vector_current) else $error("vector read lost the winner"); // RL21

  // Fast vector read drops latch 0 unless a fresh pin edge lands with it
  property p_fast_vector_clear;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && !wr_i && addr_i == visc_pkg::FAST_VECTOR_OFS && q.in_prev[0] == q.in_s2[0]
      |=> !q.edge_lat[0];
  endproperty
  a_fast_vector_clear: assert property (p_fast_vector_clear) else $error("fast vector read kept latch 0"); // RL19

  // Redirected sources are fast only, so a vector read leaves their latch
  property p_redirect_kept;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i && !wr_i && addr_i == visc_pkg::VECTOR_OFS && q.fast_redir[2] && is_edge(q.mode[2]) && q.edge_lat[2]
      |=> q.edge_lat[2];
  endproperty
  a_redirect_kept: assert property (p_redirect_kept) else $error("redirected latch cleared by vector read"); // RL18

  // Masked activity alone never pulls a request line low
  property p_masked_quiet;
    @(posedge clk_i) disable iff (!rst_n)
      (pending & q.mask) == 32'h0 |=> fast_request_n_o && normal_request_n_o;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("request without enabled activity"); // RL14

  // Set commands leave a level source without a latch
  property p_level_set_ignored;
    @(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == visc_pkg::SET_CMD_OFS && wdata_i[3] && !is_edge(q.mode[3]) |=> !q.edge_lat[3];
  endproperty
  a_level_set_ignored: assert property (p_level_set_ignored) else $error("set latched a level source"); // RL16
endmodule

/* File: hdl/visc_pkg.sv */
// Package: register offsets, field layout, reset values and encodings of the source-control block
package visc_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [11:0] MODE_BASE_OFS      = 12'h000; // Source mode registers, 32 words
  localparam logic [11:0] VECTOR_OFS         = 12'h100;
  localparam logic [11:0] FAST_VECTOR_OFS    = 12'h104;
  localparam logic [11:0] CURRENT_SOURCE_OFS = 12'h108;
  localparam logic [11:0] PENDING_OFS        = 12'h10C;
  localparam logic [11:0] MASK_OFS           = 12'h110;
  localparam logic [11:0] CORE_STATUS_OFS    = 12'h114;
  localparam logic [11:0] ENABLE_CMD_OFS     = 12'h120;
  localparam logic [11:0] DISABLE_CMD_OFS    = 12'h124;
  localparam logic [11:0] CLEAR_CMD_OFS      = 12'h128;
  localparam logic [11:0] SET_CMD_OFS        = 12'h12C;
  localparam logic [11:0] END_SERVICE_OFS    = 12'h130;
  localparam logic [11:0] FAST_REDIRECT_OFS  = 12'h140;
  localparam logic [11:0] CONTROL_OFS        = 12'h148;

  // Mode register fields
  localparam int PRIO_LSB = 0;
  localparam int PRIO_MSB = 2;
  localparam int TYPE_LSB = 5;
  localparam int TYPE_MSB = 6;

  // Trigger condition encoding
  localparam logic [1:0] TYPE_LOW_LEVEL  = 2'h0; // Internal: level
  localparam logic [1:0] TYPE_FALL_EDGE  = 2'h1; // Internal: edge
  localparam logic [1:0] TYPE_HIGH_LEVEL = 2'h2;
  localparam logic [1:0] TYPE_RISE_EDGE  = 2'h3;

  // Control register bits
  localparam int CTRL_WAKE_ONLY_BIT = 0;

  // Core status bits
  localparam int CORE_FAST_BIT   = 0;
  localparam int CORE_NORMAL_BIT = 1;

  // Reset values
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [6:0]  MODE_RESET  = 7'h00;
  localparam logic [4:0]  NO_SOURCE   = 5'h00;

  // Service state
  typedef enum logic [1:0] {
    VISC_IDLE = 2'b01,
    VISC_BUSY = 2'b10
  } visc_state_type;
endpackage

/* File: sim/tb_visc_core.sv */
// Self-checking testbench of the source-control block
`timescale 1ns/10ps
module tb_visc_core;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        fast_source_pin_i = 1'b0;
  logic [7:0]  system_lines_i = 8'h00;
  logic [29:0] peripheral_sources_i = 30'h0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic        fast_request_n_o;
  logic        normal_request_n_o;
  logic        wake_o;
  logic [7:0]  fcnt;
  logic [7:0]  ncnt;
  logic        woke;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #25 clk_i = ~clk_i;

  visc_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .fast_source_pin_i(fast_source_pin_i),
    .system_lines_i(system_lines_i), .peripheral_sources_i(peripheral_sources_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fast_request_n_o(fast_request_n_o), .normal_request_n_o(normal_request_n_o), .wake_o(wake_o));

  visc_core_model core (.clk_i(clk_i), .fast_request_n_i(fast_request_n_o),
    .normal_request_n_i(normal_request_n_o), .wake_i(wake_o), .fast_count_o(fcnt),
    .normal_count_o(ncnt), .woke_o(woke));

  // ---------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  task automatic md(input int s, input logic [31:0] v);
    wr(visc_pkg::MODE_BASE_OFS + 12'(s * 4), v);
  endtask

  // Sources pass two sync flops and an edge stage, so allow a margin
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset;
    rd(visc_pkg::MASK_OFS);
    chk(rv, visc_pkg::MASK_RESET, "mask");
    // Source 0 resets as a low-level pin source and its pin idles low
    rd(visc_pkg::PENDING_OFS);
    chk(rv, 32'h0000_0001, "pending");
    rd(visc_pkg::CORE_STATUS_OFS);
    chk(rv, 32'h0, "core");
    chk(32'(fast_request_n_o & normal_request_n_o), 32'h1, "lines");
    rd(12'hFF0);
    chk(rv, 32'h0, "unmapped");
    $display("reset test done");
  endtask

  task automatic t_mask;
    wr(visc_pkg::ENABLE_CMD_OFS, 32'h8000_0005);
    rd(visc_pkg::MASK_OFS);
    chk(rv, 32'h8000_0005, "enable");
    wr(visc_pkg::DISABLE_CMD_OFS, 32'h8000_0001);
    rd(visc_pkg::MASK_OFS);
    chk(rv, 32'h0000_0004, "disable");
    $display("mask test done");
  endtask

  // Source 2 edge and enabled, source 3 level and masked
  task automatic t_setclr;
    md(2, 32'h20);
    wr(visc_pkg::SET_CMD_OFS, 32'hC);
    idle(2);
    rd(visc_pkg::PENDING_OFS);
    chk(rv, 32'h5, "set");
    @(posedge clk_i);
    peripheral_sources_i <= 30'h2;
    idle(8);
    wr(visc_pkg::CLEAR_CMD_OFS, 32'hC);
    idle(2);
    rd(visc_pkg::PENDING_OFS);
    chk(rv, 32'h9, "clear");
    @(posedge clk_i);
    peripheral_sources_i <= 30'h0;
    system_lines_i <= 8'h20;
    idle(8);
    rd(visc_pkg::PENDING_OFS);
    chk(rv, 32'h3, "system");
    chk(32'(normal_request_n_o), 32'h1, "masked");
    @(posedge clk_i);
    system_lines_i <= 8'h00;
    idle(8);
    $display("set clear test done");
  endtask

  // Two sources tie at 7; a masked 7 must not get in the way
  task automatic t_prio;
    md(2, 32'h25);
    md(4, 32'h27);
    md(5, 32'h27);
    md(6, 32'h27);
    wr(visc_pkg::ENABLE_CMD_OFS, 32'h34);
    wr(visc_pkg::SET_CMD_OFS, 32'h74);
    idle(6);
    chk(32'(normal_request_n_o), 32'h0, "irq");
    rd(visc_pkg::CORE_STATUS_OFS);
    chk(rv, 32'h2, "core");
    rd(visc_pkg::VECTOR_OFS);
    chk(rv, 32'h4, "vector");
    chk(32'(normal_request_n_o), 32'h1, "irq off");
    rd(visc_pkg::PENDING_OFS);
    chk(rv, 32'h65, "autoclr");
    rd(visc_pkg::CURRENT_SOURCE_OFS);
    chk(rv, 32'h4, "current");
    wr(visc_pkg::END_SERVICE_OFS, 32'h0);
    idle(4);
    rd(visc_pkg::VECTOR_OFS);
    chk(rv, 32'h5, "vector2");
    wr(visc_pkg::END_SERVICE_OFS, 32'h0);
    wr(visc_pkg::CLEAR_CMD_OFS, 32'h74);
    wr(visc_pkg::DISABLE_CMD_OFS, 32'h30);
    idle(4);
    chk(32'(normal_request_n_o), 32'h1, "idle");
    $display("priority test done");
  endtask

  // The mask test already pulled the fast line once, so count from here
  task automatic t_fast;
    logic [7:0] f0;
    f0 = fcnt;
    md(0, 32'h60);
    wr(visc_pkg::ENABLE_CMD_OFS, 32'h1);
    fast_source_pin_i <= 1'b1;
    idle(8);
    chk(32'(fast_request_n_o), 32'h0, "fiq");
    chk(32'(fcnt), 32'(f0 + 8'h01), "core fiq");
    rd(visc_pkg::FAST_VECTOR_OFS);
    chk(rv, 32'h0, "fvec");
    rd(visc_pkg::PENDING_OFS);
    chk(32'(rv[0]), 32'h0, "fclr");
    md(0, 32'h20);
    fast_source_pin_i <= 1'b0;
    idle(8);
    rd(visc_pkg::PENDING_OFS);
    chk(32'(rv[0]), 32'h1, "fall");
    wr(visc_pkg::DISABLE_CMD_OFS, 32'h1);
    wr(visc_pkg::CLEAR_CMD_OFS, 32'h1);
    md(0, 32'h40);
    fast_source_pin_i <= 1'b1;
    idle(6);
    rd(visc_pkg::PENDING_OFS);
    chk(32'(rv[0]), 32'h1, "high");
    @(posedge clk_i);
    fast_source_pin_i <= 1'b0;
    $display("fast test done");
  endtask

  task automatic t_redirect;
    logic [7:0] n0;
    wr(visc_pkg::FAST_REDIRECT_OFS, 32'h4);
    wr(visc_pkg::SET_CMD_OFS, 32'h4);
    idle(4);
    chk(32'({fast_request_n_o, normal_request_n_o}), 32'h1, "redir");
    rd(visc_pkg::VECTOR_OFS);
    rd(visc_pkg::PENDING_OFS);
    chk(32'(rv[2]), 32'h1, "kept");
    wr(visc_pkg::END_SERVICE_OFS, 32'h0);
    wr(visc_pkg::CLEAR_CMD_OFS, 32'h4);
    wr(visc_pkg::FAST_REDIRECT_OFS, 32'h0);
    wr(visc_pkg::CONTROL_OFS, 32'h1);
    n0 = ncnt;
    wr(visc_pkg::SET_CMD_OFS, 32'h4);
    idle(4);
    chk(32'({wake_o, normal_request_n_o, woke}), 32'h7, "wake");
    chk(32'(ncnt), 32'(n0), "no irq");
    wr(visc_pkg::CLEAR_CMD_OFS, 32'h4);
    wr(visc_pkg::CONTROL_OFS, 32'h0);
    $display("redirect wake test done");
  endtask

  // ---------------------------------------------
  // Run control
  // ---------------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is about two hundred cycles; a hang ends here
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    idle(4);
    t_reset();
    t_mask();
    t_setclr();
    t_prio();
    t_fast();
    t_redirect();
    tally_and_finish();
  end
endmodule

/* File: sim/visc_core_model.sv */
// Processor core model watching the request and wake lines
`timescale 1ns/10ps
module visc_core_model (
  // Clock
  input  wire logic       clk_i,
  // Lines from the controller
  input  wire logic       fast_request_n_i,
  input  wire logic       normal_request_n_i,
  input  wire logic       wake_i,
  // What the core has seen
  output logic      [7:0] fast_count_o,
  output logic      [7:0] normal_count_o,
  output logic            woke_o
);
  logic fast_q;
  logic norm_q;

  initial begin
    fast_count_o = 8'h00;
    normal_count_o = 8'h00;
    woke_o = 1'b0;
  end

  // Core samples the lines on its clock; only falling lines count as requests
  always @(posedge clk_i) begin
    fast_q <= fast_request_n_i;
    norm_q <= normal_request_n_i;
    if (fast_q && !fast_request_n_i) fast_count_o <= fast_count_o + 8'h01;
    if (norm_q && !normal_request_n_i) normal_count_o <= normal_count_o + 8'h01;
    if (wake_i) woke_o <= 1'b1;
  end
endmodule
